// ### verilog/ppv_programmer.v
// host-side sequencer that programs and verifies a uv-erasable byte-wide prom
`include "ppv_defs.vh"
`default_nettype none

// How it works
// - switch device supply on before anything else
// - raise strobes and enable, then programming voltage
// - present address, then drive the byte pattern
// - program strobe low for one nominal millisecond
// - verify strobe low after each pulse, compare byte
// - retry data, pulse, verify up to 25 times
// - overprogram at 5.0 V, twice summed pulse width
// - repeat whole sequence for every address
// - margin read every address at 6.0 and 4.2 V
// - drop programming voltage back to high level
// - at least one microsecond between timing events
// - never both strobes low under programming voltage
// - fourth output enable held low throughout
// - address setup and hold around each strobe
// - data setup and hold around program strobe
// - sample data pins at least 100 ns after verify falls
module ppv_programmer #(
  parameter AW         = `PPV_ADDR_W,
  parameter PULSE_CYC  = `PPV_PULSE_CYC,
  parameter SETTLE_CYC = `PPV_SETTLE_CYC
) (
  input  wire          I_SYS_CLK,
  input  wire          I_RST_N,
  input  wire          I_START,
  input  wire [AW-1:0] I_FIRST_ADDR,
  input  wire [AW-1:0] I_LAST_ADDR,
  output wire          O_BYTE_REQ,
  input  wire          I_BYTE_VALID,
  input  wire [7:0]    I_BYTE,
  output wire          O_BUSY,
  output reg           O_DONE,
  output reg           O_FAIL,
  output reg  [AW-1:0] O_FAIL_ADDR,
  output reg           O_FAIL_MARGIN,
  output reg           O_VCC_ON,
  output reg  [1:0]    O_VCC_SEL,
  output reg  [AW-1:0] O_ADDR,
  input  wire [7:0]    I_DATA_PINS,
  output reg  [7:0]    O_DATA_PINS,
  output reg           O_DATA_PINS_OE,
  output reg           O_PROGRAM_STROBE_N,
  output reg           O_VERIFY_STROBE_N,
  output reg           O_ENABLE_PROG_HIGH,
  output reg           O_ENABLE_PROG_VPP,
  output wire          O_FOURTH_OUTPUT_ENABLE
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'h00;
  localparam [4:0] S_PWR   = 5'h01;
  localparam [4:0] S_HIGH  = 5'h02;
  localparam [4:0] S_VPP   = 5'h03;
  localparam [4:0] S_REQ   = 5'h04;
  localparam [4:0] S_DSET  = 5'h05;
  localparam [4:0] S_PLOW  = 5'h06;
  localparam [4:0] S_PHI   = 5'h07;
  localparam [4:0] S_REL   = 5'h08;
  localparam [4:0] S_VLOW  = 5'h09;
  localparam [4:0] S_VHI   = 5'h0A;
  localparam [4:0] S_OVSUP = 5'h0B;
  localparam [4:0] S_OVDAT = 5'h0C;
  localparam [4:0] S_OVLOW = 5'h0D;
  localparam [4:0] S_OVHI  = 5'h0E;
  localparam [4:0] S_OVREL = 5'h0F;
  localparam [4:0] S_MGSUP = 5'h10;
  localparam [4:0] S_MREQ  = 5'h11;
  localparam [4:0] S_MSET  = 5'h12;
  localparam [4:0] S_MLOW  = 5'h13;
  localparam [4:0] S_MHI   = 5'h14;
  localparam [4:0] S_END   = 5'h15;

  localparam TW = `PPV_TMR_W;
  localparam [TW-1:0] STEP   = `PPV_STEP_CYC;
  localparam [TW-1:0] PULSE  = PULSE_CYC;
  localparam [TW-1:0] SETTLE = SETTLE_CYC;
  // verify low time covers both the sample delay and the 1 us spacing
  localparam [TW-1:0] VFY_LOW = (`PPV_STEP_CYC > `PPV_SAMPLE_CYC) ?
                                `PPV_STEP_CYC : `PPV_SAMPLE_CYC;
  localparam [`PPV_TRY_W-1:0] MAX_TRIES = `PPV_MAX_TRIES;
  localparam [`PPV_TRY_W-1:0] TRY_ONE   = 5'h01;

  // ----------------------------------------------------------------
  // state and working registers
  // ----------------------------------------------------------------
  reg [4:0]            state;
  reg [AW-1:0]         last_addr;
  reg [AW-1:0]         first_addr;
  reg [7:0]            want;
  reg [`PPV_TRY_W-1:0] tries;
  reg [`PPV_TRY_W:0]   over_left;
  reg                  margin_pass;
  reg                  tmr_load;
  reg [TW-1:0]         tmr_value;
  wire                 tmr_done;

  ppv_delay_timer #(
    .CW (TW)
  ) u_timer (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_load  (tmr_load),
    .i_value (tmr_value),
    .o_done  (tmr_done)
  );

  assign O_BYTE_REQ             = (state == S_REQ) || (state == S_MREQ);
  assign O_BUSY                 = (state != S_IDLE);
  assign O_FOURTH_OUTPUT_ENABLE = 1'b0;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      state              <= S_IDLE;
      last_addr          <= {AW{1'b0}};
      first_addr         <= {AW{1'b0}};
      want               <= 8'h00;
      tries              <= {`PPV_TRY_W{1'b0}};
      over_left          <= {(`PPV_TRY_W+1){1'b0}};
      margin_pass        <= 1'b0;
      tmr_load           <= 1'b0;
      tmr_value          <= {TW{1'b0}};
      O_DONE             <= 1'b0;
      O_FAIL             <= 1'b0;
      O_FAIL_ADDR        <= {AW{1'b0}};
      O_FAIL_MARGIN      <= 1'b0;
      O_VCC_ON           <= 1'b0;
      O_VCC_SEL          <= `PPV_VCC_PROG;
      O_ADDR             <= {AW{1'b0}};
      O_DATA_PINS        <= 8'h00;
      O_DATA_PINS_OE     <= 1'b0;
      O_PROGRAM_STROBE_N <= 1'b0;
      O_VERIFY_STROBE_N  <= 1'b0;
      O_ENABLE_PROG_HIGH <= 1'b0;
      O_ENABLE_PROG_VPP  <= 1'b0;
    end else begin
      tmr_load <= 1'b0;
      O_DONE   <= 1'b0;
      case (state)
        S_IDLE: begin
          if (I_START) begin
            first_addr <= I_FIRST_ADDR;
            last_addr  <= I_LAST_ADDR;
            O_ADDR     <= I_FIRST_ADDR;
            O_FAIL     <= 1'b0;
            O_VCC_ON   <= 1'b1;
            O_VCC_SEL  <= `PPV_VCC_PROG;
            tmr_load   <= 1'b1;
            tmr_value  <= SETTLE;
            state      <= S_PWR;
          end
        end
        S_PWR: begin
          if (tmr_done) begin
            O_PROGRAM_STROBE_N <= 1'b1;
            O_VERIFY_STROBE_N  <= 1'b1;
            O_ENABLE_PROG_HIGH <= 1'b1;
            tmr_load           <= 1'b1;
            tmr_value          <= STEP;
            state              <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (tmr_done) begin
            O_ENABLE_PROG_VPP <= 1'b1;
            tmr_load          <= 1'b1;
            tmr_value         <= SETTLE;
            state             <= S_VPP;
          end
        end
        S_VPP: begin
          if (tmr_done) begin
            state <= S_REQ;
          end
        end
        S_REQ: begin
          if (I_BYTE_VALID) begin
            want      <= I_BYTE;
            tries     <= {`PPV_TRY_W{1'b0}};
            O_DATA_PINS    <= I_BYTE;
            O_DATA_PINS_OE <= 1'b1;
            tmr_load  <= 1'b1;
            tmr_value <= STEP;
            state     <= S_DSET;
          end
        end
        S_DSET: begin
          if (tmr_done) begin
            O_PROGRAM_STROBE_N <= 1'b0;
            tries              <= tries + TRY_ONE;
            tmr_load           <= 1'b1;
            tmr_value          <= PULSE;
            state              <= S_PLOW;
          end
        end
        S_PLOW: begin
          if (tmr_done) begin
            O_PROGRAM_STROBE_N <= 1'b1;
            tmr_load           <= 1'b1;
            tmr_value          <= STEP;
            state              <= S_PHI;
          end
        end
        S_PHI: begin
          if (tmr_done) begin
            // the device drives the pins during verify, so let go first
            O_DATA_PINS_OE <= 1'b0;
            tmr_load       <= 1'b1;
            tmr_value      <= STEP;
            state          <= S_REL;
          end
        end
        S_REL: begin
          if (tmr_done) begin
            O_VERIFY_STROBE_N <= 1'b0;
            tmr_load          <= 1'b1;
            tmr_value         <= VFY_LOW;
            state             <= S_VLOW;
          end
        end
        S_VLOW: begin
          if (tmr_done) begin
            // compare with strobe still low; a match is remembered in over_left as twice tries
            if (I_DATA_PINS == want) begin
              over_left <= {tries, 1'b0};
            end else begin
              over_left <= {(`PPV_TRY_W+1){1'b0}};
            end
            O_VERIFY_STROBE_N <= 1'b1;
            tmr_load          <= 1'b1;
            tmr_value         <= STEP;
            state             <= S_VHI;
          end
        end
        S_VHI: begin
          if (tmr_done) begin
            if (over_left != {(`PPV_TRY_W+1){1'b0}}) begin
              O_VCC_SEL <= `PPV_VCC_OVER;
              tmr_load  <= 1'b1;
              tmr_value <= SETTLE;
              state     <= S_OVSUP;
            end else if (tries < MAX_TRIES) begin
              O_DATA_PINS_OE <= 1'b1;
              tmr_load       <= 1'b1;
              tmr_value      <= STEP;
              state          <= S_DSET;
            end else begin
              O_FAIL            <= 1'b1;
              O_FAIL_ADDR       <= O_ADDR;
              O_FAIL_MARGIN     <= 1'b0;
              O_ENABLE_PROG_VPP <= 1'b0;
              tmr_load          <= 1'b1;
              tmr_value         <= SETTLE;
              state             <= S_END;
            end
          end
        end
        S_OVSUP: begin
          if (tmr_done) begin
            O_DATA_PINS_OE <= 1'b1;
            tmr_load       <= 1'b1;
            tmr_value      <= STEP;
            state          <= S_OVDAT;
          end
        end
        S_OVDAT: begin
          if (tmr_done) begin
            O_PROGRAM_STROBE_N <= 1'b0;
            tmr_load           <= 1'b1;
            tmr_value          <= PULSE;
            state              <= S_OVLOW;
          end
        end
        S_OVLOW: begin
          // one long pulse built from 2 x tries nominal slices
          if (tmr_done) begin
            tmr_load <= 1'b1;
            if (over_left == {{`PPV_TRY_W{1'b0}}, 1'b1}) begin
              O_PROGRAM_STROBE_N <= 1'b1;
              tmr_value          <= STEP;
              state              <= S_OVHI;
            end else begin
              over_left <= over_left - {{`PPV_TRY_W{1'b0}}, 1'b1};
              tmr_value <= PULSE;
            end
          end
        end
        S_OVHI: begin
          if (tmr_done) begin
            O_DATA_PINS_OE <= 1'b0;
            O_VCC_SEL      <= `PPV_VCC_PROG;
            tmr_load       <= 1'b1;
            tmr_value      <= SETTLE;
            state          <= S_OVREL;
          end
        end
        S_OVREL: begin
          if (tmr_done) begin
            tmr_load <= 1'b1;
            if (O_ADDR == last_addr) begin
              margin_pass <= 1'b0;
              O_ADDR      <= first_addr;
              O_VCC_SEL   <= `PPV_VCC_MARGIN_HI;
              tmr_value   <= SETTLE;
              state       <= S_MGSUP;
            end else begin
              O_ADDR    <= O_ADDR + {{(AW-1){1'b0}}, 1'b1};
              tmr_value <= STEP;
              state     <= S_VPP;
            end
          end
        end
        S_MGSUP: begin
          if (tmr_done) begin
            state <= S_MREQ;
          end
        end
        S_MREQ: begin
          if (I_BYTE_VALID) begin
            want      <= I_BYTE;
            tmr_load  <= 1'b1;
            tmr_value <= STEP;
            state     <= S_MSET;
          end
        end
        S_MSET: begin
          if (tmr_done) begin
            O_VERIFY_STROBE_N <= 1'b0;
            tmr_load          <= 1'b1;
            tmr_value         <= VFY_LOW;
            state             <= S_MLOW;
          end
        end
        S_MLOW: begin
          if (tmr_done) begin
            if (I_DATA_PINS != want) begin
              O_FAIL        <= 1'b1;
              O_FAIL_ADDR   <= O_ADDR;
              O_FAIL_MARGIN <= 1'b1;
            end
            O_VERIFY_STROBE_N <= 1'b1;
            tmr_load          <= 1'b1;
            tmr_value         <= STEP;
            state             <= S_MHI;
          end
        end
        S_MHI: begin
          if (tmr_done) begin
            tmr_load <= 1'b1;
            if (O_FAIL || (O_ADDR == last_addr && margin_pass)) begin
              O_ENABLE_PROG_VPP <= 1'b0;
              O_VCC_SEL         <= `PPV_VCC_PROG;
              tmr_value         <= SETTLE;
              state             <= S_END;
            end else if (O_ADDR == last_addr) begin
              margin_pass <= 1'b1;
              O_ADDR      <= first_addr;
              O_VCC_SEL   <= `PPV_VCC_MARGIN_LO;
              tmr_value   <= SETTLE;
              state       <= S_MGSUP;
            end else begin
              O_ADDR    <= O_ADDR + {{(AW-1){1'b0}}, 1'b1};
              tmr_value <= STEP;
              state     <= S_MGSUP;
            end
          end
        end
        S_END: begin
          // pin stays at the programming high level, supply stays on
          if (tmr_done) begin
            O_VCC_SEL <= `PPV_VCC_PROG;
            O_DONE    <= 1'b1;
            state     <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### verilog/ppv_defs.vh
// constants for the prom byte program/verify sequencer
`ifndef PPV_DEFS_VH
`define PPV_DEFS_VH

// ------------------------------------------------------------------
// clock and timing figures
// ------------------------------------------------------------------
`define PPV_CLK_NS          100
`define PPV_STEP_NS         1000
`define PPV_SAMPLE_NS       100
`define PPV_PULSE_US        1000
`define PPV_SETTLE_US       10
// least times, rounded up to whole cycles
`define PPV_STEP_CYC        ((`PPV_STEP_NS + `PPV_CLK_NS - 1) / `PPV_CLK_NS)
`define PPV_SAMPLE_CYC      ((`PPV_SAMPLE_NS + `PPV_CLK_NS - 1) / `PPV_CLK_NS)
// nominal pulse, inside its 0.95 to 1.05 ms window
`define PPV_PULSE_CYC       ((`PPV_PULSE_US * 1000) / `PPV_CLK_NS)
`define PPV_SETTLE_CYC      ((`PPV_SETTLE_US * 1000 + `PPV_CLK_NS - 1) / `PPV_CLK_NS)

// ------------------------------------------------------------------
// sizes and limits
// ------------------------------------------------------------------
`define PPV_ADDR_W          11
`define PPV_MAX_TRIES       25
`define PPV_TRY_W           5
`define PPV_TMR_W           20

// ------------------------------------------------------------------
// supply selection codes
// ------------------------------------------------------------------
`define PPV_VCC_PROG        2'h0
`define PPV_VCC_OVER        2'h1
`define PPV_VCC_MARGIN_HI   2'h2
`define PPV_VCC_MARGIN_LO   2'h3

`endif

// ### verilog/ppv_delay_timer.v
// loadable down counter that marks the end of a wait
`default_nettype none

module ppv_delay_timer #(
  parameter CW = 20
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_load,
  input  wire [CW-1:0] i_value,
  output wire          o_done
);

  reg [CW-1:0] count;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      count <= {CW{1'b0}};
    end else if (i_load) begin
      count <= i_value;
    end else if (count != {CW{1'b0}}) begin
      count <= count - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // a load in progress hides the stale zero of the previous wait
  assign o_done = (count == {CW{1'b0}}) && !i_load;

endmodule

`default_nettype wire

// ### verif/ppv_checker_properties.sv
// concurrent checks on the pins of the prom program/verify sequencer
`default_nettype none
module ppv_checker #(
  parameter AW        = 11,
  parameter PULSE_CYC = 20
) (
  input wire          I_SYS_CLK,
  input wire          I_RST_N,
  input wire          O_DONE,
  input wire          O_VCC_ON,
  input wire [1:0]    O_VCC_SEL,
  input wire [AW-1:0] O_ADDR,
  input wire [7:0]    O_DATA_PINS,
  input wire          O_DATA_PINS_OE,
  input wire          O_PROGRAM_STROBE_N,
  input wire          O_VERIFY_STROBE_N,
  input wire          O_ENABLE_PROG_HIGH,
  input wire          O_ENABLE_PROG_VPP,
  input wire          O_FOURTH_OUTPUT_ENABLE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // pulse width bookkeeping
  // ------------------------------
  // wide enough for 2 x 25 slices at the full-length pulse
  reg [23:0]   lo_cnt;
  reg [5:0]    try_cnt;
  reg          pg_q;
  reg [AW-1:0] addr_q;
  // tries are counted per address, so the over-pulse can be tied to them
  always @(posedge I_SYS_CLK) begin
    pg_q <= O_PROGRAM_STROBE_N;
    addr_q <= O_ADDR;
    if (!I_RST_N || O_PROGRAM_STROBE_N) lo_cnt <= 24'h000000;
    else lo_cnt <= lo_cnt + 24'h000001;
    if (!I_RST_N || O_ADDR != addr_q) try_cnt <= 6'h00;
    else if (O_PROGRAM_STROBE_N && !pg_q && O_ENABLE_PROG_VPP && O_VCC_SEL == 2'h0)
      try_cnt <= try_cnt + 6'h01;
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_pg_fell; $fell(O_PROGRAM_STROBE_N); endsequence
  sequence s_pg_rose; $rose(O_PROGRAM_STROBE_N) && O_ENABLE_PROG_VPP; endsequence
  sequence s_any_fell; $fell(O_PROGRAM_STROBE_N) || $fell(O_VERIFY_STROBE_N); endsequence
  sequence s_any_rose; $rose(O_PROGRAM_STROBE_N) || $rose(O_VERIFY_STROBE_N); endsequence
  property p_no_overlap; O_ENABLE_PROG_VPP |-> O_PROGRAM_STROBE_N || O_VERIFY_STROBE_N; endproperty
  property p_fourth_low; O_FOURTH_OUTPUT_ENABLE == 1'b0; endproperty
  property p_vpp_order;
    $rose(O_ENABLE_PROG_VPP) |-> O_VCC_ON && $past(O_ENABLE_PROG_HIGH, 10)
      && O_PROGRAM_STROBE_N && O_VERIFY_STROBE_N;
  endproperty
  // a timed wait lasts its load value plus a load cycle and a done cycle
  property p_pulse_len; s_pg_rose ##0 O_VCC_SEL == 2'h0 |-> lo_cnt == PULSE_CYC + 2; endproperty
  property p_over_len;
    s_pg_rose ##0 O_VCC_SEL == 2'h1 |-> lo_cnt == 2 * try_cnt * (PULSE_CYC + 2);
  endproperty
  property p_addr_setup; s_any_fell |-> O_ADDR == $past(O_ADDR, 10); endproperty
  property p_addr_hold; s_any_rose |=> ($stable(O_ADDR))[*8]; endproperty
  property p_data_setup;
    s_pg_fell |-> O_DATA_PINS_OE && $past(O_DATA_PINS_OE, 10)
      && O_DATA_PINS == $past(O_DATA_PINS, 10);
  endproperty
  property p_data_hold; s_pg_rose |=> (O_DATA_PINS_OE && $stable(O_DATA_PINS))[*8]; endproperty
  property p_verify_bus; !O_VERIFY_STROBE_N |-> !O_DATA_PINS_OE; endproperty
  property p_verify_len; $fell(O_VERIFY_STROBE_N) |-> (!O_VERIFY_STROBE_N)[*8]; endproperty
  property p_done_end; O_DONE |-> !O_ENABLE_PROG_VPP && O_ENABLE_PROG_HIGH; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both strobes low");
  a_fourth_low: assert property (p_fourth_low) else $error("fourth enable high");
  a_vpp_order: assert property (p_vpp_order) else $error("vpp raised early");
  a_pulse_len: assert property (p_pulse_len) else $error("pulse width");
  a_over_len: assert property (p_over_len) else $error("over pulse width");
  a_addr_setup: assert property (p_addr_setup) else $error("address setup");
  a_addr_hold: assert property (p_addr_hold) else $error("address hold");
  a_data_setup: assert property (p_data_setup) else $error("data setup");
  a_data_hold: assert property (p_data_hold) else $error("data hold");
  a_verify_bus: assert property (p_verify_bus) else $error("host drives in verify");
  a_verify_len: assert property (p_verify_len) else $error("verify too short");
  a_done_end: assert property (p_done_end) else $error("vpp left on");
endmodule
bind ppv_programmer ppv_checker #(.AW(AW), .PULSE_CYC(PULSE_CYC)) ppv_checker_inst (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .O_DONE(O_DONE), .O_VCC_ON(O_VCC_ON),
  .O_VCC_SEL(O_VCC_SEL), .O_ADDR(O_ADDR), .O_DATA_PINS(O_DATA_PINS),
  .O_DATA_PINS_OE(O_DATA_PINS_OE), .O_PROGRAM_STROBE_N(O_PROGRAM_STROBE_N),
  .O_VERIFY_STROBE_N(O_VERIFY_STROBE_N), .O_ENABLE_PROG_HIGH(O_ENABLE_PROG_HIGH),
  .O_ENABLE_PROG_VPP(O_ENABLE_PROG_VPP), .O_FOURTH_OUTPUT_ENABLE(O_FOURTH_OUTPUT_ENABLE)
);
`default_nettype wire

// ### verif/ppv_prom_model.sv
// behavioural prom answering the sequencer's pins
`default_nettype none
module ppv_prom_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_data,
  input  wire logic       i_prog_n,
  input  wire logic       i_verify_n,
  input  wire logic       i_vpp,
  input  wire logic [1:0] i_vcc_sel,
  input  wire logic [5:0] i_need,
  input  wire logic       i_margin_bad,
  output logic      [7:0] o_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:15];
  logic [5:0] hits;
  logic       prog_q;
  logic [3:0] addr_q;
  logic [7:0] last;
  logic [7:0] rd;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
    hits = 6'h00;
    last = 8'h00;
  end
  // a cell only takes its pattern after i_need pulses, which forces retries
  always @(posedge i_clk) begin
    prog_q <= i_prog_n;
    addr_q <= i_addr;
    if (i_addr != addr_q) hits <= 6'h00;
    else if (i_vpp && i_prog_n && !prog_q && i_vcc_sel == 2'h0) begin
      hits <= hits + 6'h01;
      if (hits + 6'h01 >= i_need) mem[i_addr] <= mem[i_addr] & i_data;
    end
    if (!i_verify_n) last <= rd;
  end
  assign rd = (i_margin_bad && i_vcc_sel == 2'h3) ? ~mem[i_addr] : mem[i_addr];
  // released pins show the inverse of the last byte so a stale sample cannot pass
  assign o_q = !i_verify_n ? rd : ~last;
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the prom program/verify sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic [10:0] first = 11'h000;
  logic [10:0] last = 11'h000;
  logic        byte_valid = 1'b0;
  logic [7:0]  byte_v = 8'h00;
  logic [5:0]  need = 6'h01;
  logic        margin_bad = 1'b0;
  wire         byte_req, busy, done, fail, fail_margin, vcc_on, data_oe, prog_n, verify_n;
  wire         en_high, en_vpp;
  wire  [1:0]  vcc_sel;
  wire  [10:0] fail_addr, addr;
  wire  [7:0]  data_out, dev_q, data_pins;
  logic [7:0]  bytes [0:15];
  logic [12:0] expq [$];
  int          miscompares = 0;
  int          compares = 0;
  always #50 clk = ~clk;
  assign data_pins = data_oe ? data_out : dev_q;
  ppv_programmer #(.PULSE_CYC(20), .SETTLE_CYC(3)) ppv_programmer_inst (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_START(start), .I_FIRST_ADDR(first),
    .I_LAST_ADDR(last), .O_BYTE_REQ(byte_req), .I_BYTE_VALID(byte_valid), .I_BYTE(byte_v),
    .O_BUSY(busy), .O_DONE(done), .O_FAIL(fail), .O_FAIL_ADDR(fail_addr),
    .O_FAIL_MARGIN(fail_margin), .O_VCC_ON(vcc_on), .O_VCC_SEL(vcc_sel), .O_ADDR(addr),
    .I_DATA_PINS(data_pins), .O_DATA_PINS(data_out), .O_DATA_PINS_OE(data_oe),
    .O_PROGRAM_STROBE_N(prog_n), .O_VERIFY_STROBE_N(verify_n), .O_ENABLE_PROG_HIGH(en_high),
    .O_ENABLE_PROG_VPP(en_vpp), .O_FOURTH_OUTPUT_ENABLE()
  );
  ppv_prom_model ppv_prom_model_inst (
    .i_clk(clk), .i_addr(addr[3:0]), .i_data(data_pins), .i_prog_n(prog_n),
    .i_verify_n(verify_n), .i_vpp(en_vpp), .i_vcc_sel(vcc_sel), .i_need(need),
    .i_margin_bad(margin_bad), .o_q(dev_q)
  );
  task automatic chk_res(input logic [12:0] e, input logic [12:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD run_result exp %h got %h", e, g);
    end
  endtask
  task automatic chk_mem(input logic [3:0] a, input logic [7:0] e);
    compares++;
    if (ppv_prom_model_inst.mem[a] !== e) begin
      miscompares++;
      $display("BAD cell_%0d exp %h got %h", a, e, ppv_prom_model_inst.mem[a]);
    end
  endtask
  task automatic chk_busy(input logic e);
    compares++;
    if (busy !== e) begin
      miscompares++;
      $display("BAD busy exp %b got %b", e, busy);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run(input logic [3:0] f, input logic [3:0] l, input logic [5:0] n,
                     input logic bad, input logic [12:0] e);
    int k;
    @(negedge clk);
    first <= {7'h00, f};
    last <= {7'h00, l};
    need <= n;
    margin_bad <= bad;
    start <= 1'b1;
    expq.push_back(e);
    @(negedge clk);
    start <= 1'b0;
    chk_busy(1'b1);
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      miscompares++;
      $display("BAD run_done exp 1 got 0");
      tally_and_finish;
    end
    chk_busy(1'b0);
  endtask
  // the byte source answers each request on the next edge
  always @(negedge clk) begin
    byte_valid <= byte_req;
    byte_v <= bytes[addr[3:0]];
  end
  always @(negedge clk) begin
    if (done === 1'b1)
      chk_res(expq.pop_front(), {fail, fail_margin, fail ? fail_addr : 11'h000});
  end
  initial begin
    void'($urandom(32'hbf93));
    // bit 0 cleared so no pattern equals the erased byte
    for (int i = 0; i < 16; i++) bytes[i] = 8'($urandom) & 8'hFE;
    repeat (8) @(negedge clk);
    rst_n <= 1'b1;
    run(4'h3, 4'h5, 6'h01 + 6'($urandom % 3), 1'b0, 13'h0000);
    for (int a = 3; a <= 5; a++) chk_mem(4'(a), bytes[a]);
    $display("test range_program done");
    run(4'hA, 4'hA, 6'd25, 1'b0, 13'h0000);
    chk_mem(4'hA, bytes[10]);
    $display("test last_try_passes done");
    run(4'h6, 4'h7, 6'd26, 1'b0, {2'b10, 11'h006});
    chk_mem(4'h6, 8'hFF);
    chk_mem(4'h7, 8'hFF);
    $display("test retries_exhausted done");
    run(4'h8, 4'h9, 6'h01, 1'b1, {2'b11, 11'h008});
    chk_mem(4'h9, bytes[9]);
    $display("test margin_low_fails done");
    tally_and_finish;
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("BAD watchdog exp done got timeout");
    tally_and_finish;
  end
endmodule
`default_nettype wire
